// ==== src/emc_pkg.sv ====
// constants and types of the memory access and control registers
package emc_pkg;

  ////////////////
  // register byte addresses, even byte of each word
  localparam logic [7:0] ADDR_NULL     = 8'h00;  // always zero
  localparam logic [7:0] ADDR_WR_TGT   = 8'h02;  // write target
  localparam logic [7:0] ADDR_WR_UPPER = 8'h04;  // write data upper half
  localparam logic [7:0] ADDR_WR_LOWER = 8'h06;  // write data lower half
  localparam logic [7:0] ADDR_WR_CTL   = 8'h08;  // write control and status
  localparam logic [7:0] ADDR_RD_TGT   = 8'h0A;  // read source
  localparam logic [7:0] ADDR_RD_CTL   = 8'h0C;  // read control and status
  localparam logic [7:0] ADDR_RD_UPPER = 8'h0E;  // read data upper half
  localparam logic [7:0] ADDR_RD_LOWER = 8'h10;  // read data lower half
  localparam logic [7:0] ADDR_ACT_CTL  = 8'h1E;  // device action control

  ////////////////
  // field positions
  localparam int BIT_XFER_START = 15;  // start strobe in transfer control
  localparam int BIT_XFER_BUSY  = 8;   // transfer in progress
  localparam int BIT_XFER_DONE  = 0;   // transfer complete
  localparam int BIT_CLR_STAT   = 10;  // clear action-done and boot-done
  localparam int BIT_CLR_WARN   = 9;   // clear read warning latches
  localparam int BIT_CLR_ERR    = 8;   // clear read error latches
  localparam int ACT_MSB        = 15;  // action field top
  localparam int ACT_LSB        = 12;  // action field bottom
  localparam int KEY_MSB        = 7;   // key field top

  ////////////////
  // reset values
  localparam logic [7:0]  RST_TGT  = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [31:0] RST_DATA = 32'h0000_0000;
  localparam logic [3:0]  RST_ACT  = 4'h0;

  ////////////////
  // memory target ranges
  localparam logic [7:0] NV_FIRST     = 8'h00;
  localparam logic [7:0] NV_LAST      = 8'h1F;
  localparam logic [7:0] SHADOW_FIRST = 8'h40;
  localparam logic [7:0] SHADOW_LAST  = 8'h5F;

  ////////////////
  // action codes and keys
  localparam logic [3:0] ACT_NONE      = 4'h0;
  localparam logic [3:0] ACT_MARGIN_LO = 4'h1;
  localparam logic [3:0] ACT_MARGIN_HI = 4'h2;
  localparam logic [3:0] ACT_TURNS_RST = 4'h4;
  localparam logic [3:0] ACT_RELOAD    = 4'h5;
  localparam logic [3:0] ACT_NONE_ALT  = 4'h6;
  localparam logic [3:0] ACT_HARD_RST  = 4'h7;
  localparam logic [3:0] ACT_TEST_HALL = 4'h9;
  localparam logic [3:0] ACT_TEST_LOGC = 4'hA;
  localparam logic [3:0] ACT_TEST_BOTH = 4'hB;
  localparam logic [7:0] KEY_MEMORY    = 8'hA5;
  localparam logic [7:0] KEY_TURNS     = 8'h46;
  localparam logic [7:0] KEY_TESTS     = 8'hB9;
  localparam logic [7:0] KEY_HARD_ALT  = 8'h5A;

  ////////////////
  // timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int NV_WR_TIME_MS  = 24;
  localparam int NV_RD_TIME_US  = 2;
  localparam int NV_WR_CYCLES   = (NV_WR_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NV_RD_CYCLES   = (NV_RD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W          = 20;  // timer width
  localparam logic [TMR_W-1:0] TMR_ZERO = 20'h00000;

  ////////////////
  // carrier types
  typedef struct packed {
    logic        wr_req;  // one-cycle write request
    logic [7:0]  wr_tgt;  // write target
    logic [31:0] wr_data; // write word
    logic        rd_req;  // one-cycle read request
    logic [7:0]  rd_tgt;  // read source
  } emc_mem_req_t;

  typedef struct packed {
    logic       start;    // one-cycle action start
    logic [3:0] code;     // selected action
  } emc_act_req_t;

  typedef enum logic [1:0] {
    XF_IDLE = 2'b01,
    XF_BUSY = 2'b10
  } emc_xfer_state_t;

endpackage : emc_pkg

// ==== src/emc_regs.sv ====
// extended memory access and device action control register bank
//
// Operation
// R1: registers addressed by even byte address
// R2: null register at 0x00 reads zero
// R3: write target byte, upper byte zero
// R4: write data upper half read/write
// R5: write data lower half read/write
// R6: write start sets busy, clears done
// R7: write busy reads one during write
// R8: write done set on completion
// R9: read source byte, upper byte zero
// R10: read start sets busy, clears done
// R11: read busy reads one during read
// R12: read done set on completion, cleared on start
// R13: fetched word returned as two halves
// R14: four-bit action field selects action
// R15: action starts only with matching key
// R16: memory actions refused while locked
// R17: action field clears on completion except margin
// R18: clear bit clears action-done and boot-done
// R19: warn clear bit pulses, reads zero
// R20: error clear bit pulses, reads zero
// R21: key field write-only, reads zero
// R22: shadow transfers behave like nonvolatile ones but with no hold time
// R23: action-done cleared on start, set on completion
// R24: wrong key leaves state unchanged; the code still loads the action field from the written word when idle
// R25: host waits for busy clear
`timescale 1ns/10ps
`default_nettype none

module emc_regs #(
  parameter int NV_WR_CYC = emc_pkg::NV_WR_CYCLES,  // nonvolatile write hold time
  parameter int NV_RD_CYC = emc_pkg::NV_RD_CYCLES   // nonvolatile read hold time
) (
  // clock and reset
  input  wire logic                  CLK_SYS_I,
  input  wire logic                  RST_B_I,
  // register port from the serial interface
  input  wire logic [7:0]            REG_ADDR_I,
  input  wire logic [15:0]           REG_WDATA_I,
  input  wire logic                  REG_WR_I,
  input  wire logic                  REG_RD_I,
  output logic      [15:0]           REG_RDATA_O,
  output logic                       REG_RVALID_O,
  // memory port
  output emc_pkg::emc_mem_req_t      MEM_REQ_O,
  input  wire logic                  MEM_WR_ACK_I,
  input  wire logic                  MEM_RD_ACK_I,
  input  wire logic [31:0]           MEM_RDATA_I,
  // action port
  output emc_pkg::emc_act_req_t      ACT_REQ_O,
  input  wire logic                  ACT_DONE_I,
  input  wire logic                  UNLOCKED_I,
  // status latches
  input  wire logic                  BOOT_DONE_I,
  output logic                       STA_ACT_DONE_O,
  output logic                       STA_BOOT_DONE_O,
  output logic                       WARN_CLR_O,
  output logic                       ERR_CLR_O
);

  ////////////////
  // helpers
  // nonvolatile target, long hold
  function automatic logic is_nv(input logic [7:0] tgt);
    is_nv = (tgt >= emc_pkg::NV_FIRST) && (tgt <= emc_pkg::NV_LAST);
  endfunction

  // true when the key matches the action
  function automatic logic key_ok(input logic [3:0] act, input logic [7:0] key);
    case (act)
      emc_pkg::ACT_MARGIN_LO, emc_pkg::ACT_MARGIN_HI, emc_pkg::ACT_RELOAD: begin
        key_ok = (key == emc_pkg::KEY_MEMORY);
      end
      emc_pkg::ACT_HARD_RST: begin
        key_ok = (key == emc_pkg::KEY_MEMORY) || (key == emc_pkg::KEY_HARD_ALT);
      end
      emc_pkg::ACT_TURNS_RST: begin
        key_ok = (key == emc_pkg::KEY_TURNS);
      end
      emc_pkg::ACT_TEST_HALL, emc_pkg::ACT_TEST_LOGC, emc_pkg::ACT_TEST_BOTH: begin
        key_ok = (key == emc_pkg::KEY_TESTS);
      end
      default: begin
        key_ok = 1'b0;  // no action, nothing to start
      end
    endcase
  endfunction

  // actions refused while locked
  function automatic logic needs_unlock(input logic [3:0] act);
    needs_unlock = (act == emc_pkg::ACT_MARGIN_LO) || (act == emc_pkg::ACT_MARGIN_HI) ||
                   (act == emc_pkg::ACT_RELOAD) || (act == emc_pkg::ACT_HARD_RST);
  endfunction

  // hold time for a target
  function automatic logic [emc_pkg::TMR_W-1:0] hold_cycles(input logic [7:0] tgt,
                                                            input int       nv_cyc);
    hold_cycles = is_nv(tgt) ? emc_pkg::TMR_W'(nv_cyc) : emc_pkg::TMR_ZERO;
  endfunction

  ////////////////
  // state
  logic [7:0]                     wr_tgt_q,   wr_tgt_d;    // write target
  logic [15:0]                    wr_hi_q,    wr_hi_d;     // write upper half
  logic [15:0]                    wr_lo_q,    wr_lo_d;     // write lower half
  emc_pkg::emc_xfer_state_t       wst_q,      wst_d;       // write engine
  logic                           wr_done_q,  wr_done_d;   // write done flag
  logic                           wr_ack_q,   wr_ack_d;    // memory took write
  logic [emc_pkg::TMR_W-1:0]      wr_tmr_q,   wr_tmr_d;    // write hold timer
  logic [7:0]                     rd_tgt_q,   rd_tgt_d;    // read source
  emc_pkg::emc_xfer_state_t       rst_q,      rst_d;       // read engine
  logic                           rd_done_q,  rd_done_d;   // read done flag
  logic                           rd_ack_q,   rd_ack_d;    // memory returned data
  logic [emc_pkg::TMR_W-1:0]      rd_tmr_q,   rd_tmr_d;    // read hold timer
  logic [31:0]                    rd_data_q,  rd_data_d;   // fetched word
  logic [3:0]                     act_q,      act_d;       // selected action
  logic                           act_busy_q, act_busy_d;  // action running
  logic                           sdn_q,      sdn_d;       // action done flag
  logic                           bdn_q,      bdn_d;       // boot done flag
  emc_pkg::emc_mem_req_t          mem_q,      mem_d;       // memory request
  emc_pkg::emc_act_req_t          areq_q,     areq_d;      // action request
  logic                           wclr_q,     wclr_d;      // warn clear pulse
  logic                           eclr_q,     eclr_d;      // error clear pulse
  logic [15:0]                    rdata_q,    rdata_d;     // read data out
  logic                           rvld_q;                  // read data valid

  ////////////////
  // address decode, low address bit ignored
  wire logic [7:0] word_addr = {REG_ADDR_I[7:1], 1'b0};  // R1
  wire logic sel_wtgt  = (word_addr == emc_pkg::ADDR_WR_TGT);
  wire logic sel_whi   = (word_addr == emc_pkg::ADDR_WR_UPPER);
  wire logic sel_wlo   = (word_addr == emc_pkg::ADDR_WR_LOWER);
  wire logic sel_wctl  = (word_addr == emc_pkg::ADDR_WR_CTL);
  wire logic sel_rtgt  = (word_addr == emc_pkg::ADDR_RD_TGT);
  wire logic sel_rctl  = (word_addr == emc_pkg::ADDR_RD_CTL);
  wire logic sel_rhi   = (word_addr == emc_pkg::ADDR_RD_UPPER);
  wire logic sel_rlo   = (word_addr == emc_pkg::ADDR_RD_LOWER);
  wire logic sel_actl  = (word_addr == emc_pkg::ADDR_ACT_CTL);

  // write strobes per register
  wire logic wr_start  = REG_WR_I && sel_wctl && REG_WDATA_I[emc_pkg::BIT_XFER_START];  // R6
  wire logic rd_start  = REG_WR_I && sel_rctl && REG_WDATA_I[emc_pkg::BIT_XFER_START];  // R10
  wire logic ctl_wr    = REG_WR_I && sel_actl;
  wire logic [3:0] new_act = REG_WDATA_I[emc_pkg::ACT_MSB:emc_pkg::ACT_LSB];
  wire logic [7:0] key     = REG_WDATA_I[emc_pkg::KEY_MSB:0];
  // key write fires the armed action
  wire logic act_fire  = ctl_wr && !act_busy_q && key_ok(act_q, key) &&
                         (!needs_unlock(act_q) || UNLOCKED_I);  // R15 R16 R24
  wire logic is_margin = (act_q == emc_pkg::ACT_MARGIN_LO) ||
                         (act_q == emc_pkg::ACT_MARGIN_HI);
  wire logic act_end   = act_busy_q && ACT_DONE_I;
  // done: ack seen and hold spent
  wire logic wr_fin = (wst_q == emc_pkg::XF_BUSY) && (wr_ack_q || MEM_WR_ACK_I) &&
                      (wr_tmr_q == emc_pkg::TMR_ZERO);
  wire logic rd_fin = (rst_q == emc_pkg::XF_BUSY) && (rd_ack_q || MEM_RD_ACK_I) &&
                      (rd_tmr_q == emc_pkg::TMR_ZERO);

  ////////////////
  // register stores
  assign wr_tgt_d = (REG_WR_I && sel_wtgt) ? REG_WDATA_I[7:0] : wr_tgt_q;  // R3 R22
  assign wr_hi_d  = (REG_WR_I && sel_whi)  ? REG_WDATA_I : wr_hi_q;       // R4
  assign wr_lo_d  = (REG_WR_I && sel_wlo)  ? REG_WDATA_I : wr_lo_q;       // R5
  assign rd_tgt_d = (REG_WR_I && sel_rtgt) ? REG_WDATA_I[7:0] : rd_tgt_q;  // R9 R22

  ////////////////
  // write engine
  always_comb begin
    wst_d     = wst_q;
    wr_done_d = wr_done_q;
    wr_ack_d  = wr_ack_q;
    wr_tmr_d  = wr_tmr_q;
    case (wst_q)
      emc_pkg::XF_IDLE: begin
        if (wr_start) begin
          wst_d     = emc_pkg::XF_BUSY;  // R6 R7
          wr_done_d = 1'b0;  // R6
          wr_ack_d  = 1'b0;
          wr_tmr_d  = hold_cycles(wr_tgt_q, NV_WR_CYC);  // R3
        end
      end
      emc_pkg::XF_BUSY: begin
        if (MEM_WR_ACK_I) begin
          wr_ack_d = 1'b1;
        end
        if (wr_tmr_q != emc_pkg::TMR_ZERO) begin
          wr_tmr_d = wr_tmr_q - 1'b1;
        end
        if (wr_fin) begin
          wst_d     = emc_pkg::XF_IDLE;
          wr_done_d = 1'b1;  // R8
        end
      end
      default: begin
        wst_d = emc_pkg::XF_IDLE;
      end
    endcase
  end

  ////////////////
  // read engine
  always_comb begin
    rst_d     = rst_q;
    rd_done_d = rd_done_q;
    rd_ack_d  = rd_ack_q;
    rd_tmr_d  = rd_tmr_q;
    rd_data_d = rd_data_q;
    case (rst_q)
      emc_pkg::XF_IDLE: begin
        if (rd_start) begin
          rst_d     = emc_pkg::XF_BUSY;  // R10 R11
          rd_done_d = 1'b0;  // R12
          rd_ack_d  = 1'b0;
          rd_tmr_d  = hold_cycles(rd_tgt_q, NV_RD_CYC);  // R9
        end
      end
      emc_pkg::XF_BUSY: begin
        if (MEM_RD_ACK_I) begin
          rd_ack_d  = 1'b1;
          rd_data_d = MEM_RDATA_I;  // R13
        end
        if (rd_tmr_q != emc_pkg::TMR_ZERO) begin
          rd_tmr_d = rd_tmr_q - 1'b1;
        end
        if (rd_fin) begin
          rst_d     = emc_pkg::XF_IDLE;
          rd_done_d = 1'b1;  // R12
        end
      end
      default: begin
        rst_d = emc_pkg::XF_IDLE;
      end
    endcase
  end

  ////////////////
  // memory request strobes
  always_comb begin
    mem_d         = mem_q;
    mem_d.wr_req  = wr_start && (wst_q == emc_pkg::XF_IDLE);
    mem_d.rd_req  = rd_start && (rst_q == emc_pkg::XF_IDLE);
    if (mem_d.wr_req) begin
      mem_d.wr_tgt  = wr_tgt_q;
      mem_d.wr_data = {wr_hi_q, wr_lo_q};  // R4 R5
    end
    if (mem_d.rd_req) begin
      mem_d.rd_tgt = rd_tgt_q;
    end
  end

  ////////////////
  // action control
  always_comb begin
    act_d      = act_q;
    act_busy_d = act_busy_q;
    areq_d     = '{start: 1'b0, code: act_q};
    if (ctl_wr && !act_busy_q) begin
      act_d = new_act;  // R14
    end
    if (act_fire) begin
      act_d       = act_q;  // key write keeps the armed action
      act_busy_d  = 1'b1;
      areq_d      = '{start: 1'b1, code: act_q};  // R15
    end
    if (act_end) begin
      act_busy_d = 1'b0;
      if (!is_margin) begin
        act_d = emc_pkg::ACT_NONE;  // R17
      end
    end
  end

  // status flags, set beats clear
  always_comb begin
    sdn_d = sdn_q;
    bdn_d = bdn_q;
    if (ctl_wr && REG_WDATA_I[emc_pkg::BIT_CLR_STAT]) begin
      sdn_d = 1'b0;  // R18
      bdn_d = 1'b0;  // R18
    end
    if (act_fire) begin
      sdn_d = 1'b0;  // R23
    end
    if (act_end) begin
      sdn_d = 1'b1;  // R23
    end
    if (BOOT_DONE_I) begin
      bdn_d = 1'b1;
    end
  end

  assign wclr_d = ctl_wr && REG_WDATA_I[emc_pkg::BIT_CLR_WARN];  // R19
  assign eclr_d = ctl_wr && REG_WDATA_I[emc_pkg::BIT_CLR_ERR];   // R20

  ////////////////
  // read mux, write-only bits read zero
  always_comb begin
    rdata_d = emc_pkg::RST_WORD;  // R2
    if (sel_wtgt) begin
      rdata_d = {8'h00, wr_tgt_q};  // R3
    end else if (sel_whi) begin
      rdata_d = wr_hi_q;
    end else if (sel_wlo) begin
      rdata_d = wr_lo_q;
    end else if (sel_wctl) begin
      rdata_d[emc_pkg::BIT_XFER_BUSY] = (wst_q == emc_pkg::XF_BUSY);  // R6 R7
      rdata_d[emc_pkg::BIT_XFER_DONE] = wr_done_q;  // R8
    end else if (sel_rtgt) begin
      rdata_d = {8'h00, rd_tgt_q};  // R9
    end else if (sel_rctl) begin
      rdata_d[emc_pkg::BIT_XFER_BUSY] = (rst_q == emc_pkg::XF_BUSY);  // R10 R11
      rdata_d[emc_pkg::BIT_XFER_DONE] = rd_done_q;  // R12
    end else if (sel_rhi) begin
      rdata_d = rd_data_q[31:16];  // R13
    end else if (sel_rlo) begin
      rdata_d = rd_data_q[15:0];  // R13
    end else if (sel_actl) begin
      rdata_d[emc_pkg::ACT_MSB:emc_pkg::ACT_LSB] = act_q;  // R19 R20 R21
    end
  end

  ////////////////
  // flip-flops, synchronous active-low reset
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      wr_tgt_q   <= emc_pkg::RST_TGT;
      wr_hi_q    <= emc_pkg::RST_WORD;
      wr_lo_q    <= emc_pkg::RST_WORD;
      wst_q      <= emc_pkg::XF_IDLE;
      wr_done_q  <= 1'b0;
      wr_ack_q   <= 1'b0;
      wr_tmr_q   <= emc_pkg::TMR_ZERO;
      rd_tgt_q   <= emc_pkg::RST_TGT;
      rst_q      <= emc_pkg::XF_IDLE;
      rd_done_q  <= 1'b0;
      rd_ack_q   <= 1'b0;
      rd_tmr_q   <= emc_pkg::TMR_ZERO;
      rd_data_q  <= emc_pkg::RST_DATA;
    end else begin
      wr_tgt_q   <= wr_tgt_d;
      wr_hi_q    <= wr_hi_d;
      wr_lo_q    <= wr_lo_d;
      wst_q      <= wst_d;
      wr_done_q  <= wr_done_d;
      wr_ack_q   <= wr_ack_d;
      wr_tmr_q   <= wr_tmr_d;
      rd_tgt_q   <= rd_tgt_d;
      rst_q      <= rst_d;
      rd_done_q  <= rd_done_d;
      rd_ack_q   <= rd_ack_d;
      rd_tmr_q   <= rd_tmr_d;
      rd_data_q  <= rd_data_d;
    end
  end

  // action, status and output flip-flops
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      act_q      <= emc_pkg::RST_ACT;
      act_busy_q <= 1'b0;
      sdn_q      <= 1'b0;
      bdn_q      <= 1'b0;
      mem_q      <= '0;
      areq_q     <= '0;
      wclr_q     <= 1'b0;
      eclr_q     <= 1'b0;
      rdata_q    <= emc_pkg::RST_WORD;
      rvld_q     <= 1'b0;
    end else begin
      act_q      <= act_d;
      act_busy_q <= act_busy_d;
      sdn_q      <= sdn_d;
      bdn_q      <= bdn_d;
      mem_q      <= mem_d;
      areq_q     <= areq_d;
      wclr_q     <= wclr_d;
      eclr_q     <= eclr_d;
      rdata_q    <= REG_RD_I ? rdata_d : rdata_q;
      rvld_q     <= REG_RD_I;
    end
  end

  ////////////////
  // outputs
  assign REG_RDATA_O     = rdata_q;
  assign REG_RVALID_O    = rvld_q;
  assign MEM_REQ_O       = mem_q;
  assign ACT_REQ_O       = areq_q;
  assign STA_ACT_DONE_O  = sdn_q;
  assign STA_BOOT_DONE_O = bdn_q;
  assign WARN_CLR_O      = wclr_q;
  assign ERR_CLR_O       = eclr_q;

endmodule  // emc_regs

`default_nettype wire

// ==== test/emc_regs_props.sv ====
// assertion checker on the register bank ports
`timescale 1ns/10ps
`default_nettype none
module emc_regs_props (
  // watched ports
  input wire logic                  CLK_SYS_I,
  input wire logic                  RST_B_I,
  input wire logic [7:0]            REG_ADDR_I,
  input wire logic [15:0]           REG_WDATA_I,
  input wire logic                  REG_WR_I,
  input wire logic                  REG_RD_I,
  input wire logic [15:0]           REG_RDATA_O,
  input wire logic                  REG_RVALID_O,
  input wire emc_pkg::emc_mem_req_t MEM_REQ_O,
  input wire emc_pkg::emc_act_req_t ACT_REQ_O,
  input wire logic                  ACT_DONE_I,
  input wire logic                  BOOT_DONE_I,
  input wire logic                  STA_ACT_DONE_O,
  input wire logic                  STA_BOOT_DONE_O,
  input wire logic                  WARN_CLR_O,
  input wire logic                  ERR_CLR_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_B_I);
  // word decode, low byte bit ignored
  wire logic [6:0] wa     = REG_ADDR_I[7:1];
  wire logic       ctl_wr = REG_WR_I && (wa == emc_pkg::ADDR_ACT_CTL[7:1]);
  wire logic       key_ok = REG_WDATA_I[7:0] inside {8'hA5, 8'h46, 8'hB9, 8'h5A};
  logic            run_q;  // action in flight
  ////////////////
  // track a running action
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) run_q <= 1'b0;
    else if (ACT_REQ_O.start) run_q <= 1'b1;
    else if (ACT_DONE_I) run_q <= 1'b0;
  end
  sequence s_warn; ctl_wr && REG_WDATA_I[9]; endsequence
  sequence s_err; ctl_wr && REG_WDATA_I[8]; endsequence
  sequence s_end; run_q && ACT_DONE_I; endsequence
  sequence s_cls; ctl_wr && REG_WDATA_I[10] && !BOOT_DONE_I && !(run_q && ACT_DONE_I); endsequence
  ////////////////
  AST_NULL_READ: assert property (REG_RD_I && wa == 7'h00 |=> REG_RVALID_O && REG_RDATA_O == 16'h0000)
    else $error("null word read not zero");
  AST_CTL_READ: assert property (REG_RD_I && ctl_wr == 1'b0 && wa == 7'h0F |=> REG_RDATA_O[11:0] == 12'h000)
    else $error("control low bits not zero");
  AST_WR_REQ: assert property (MEM_REQ_O.wr_req |-> $past(REG_WR_I && wa == 7'h04 && REG_WDATA_I[15]))
    else $error("write request without start");
  AST_RD_REQ: assert property (MEM_REQ_O.rd_req |-> $past(REG_WR_I && wa == 7'h06 && REG_WDATA_I[15]))
    else $error("read request without start");
  AST_WARN_CLR: assert property (s_warn |=> WARN_CLR_O)
    else $error("warning clear pulse missing");
  AST_ERR_CLR: assert property (s_err |=> ERR_CLR_O)
    else $error("error clear pulse missing");
  AST_ACT_KEY: assert property (ACT_REQ_O.start |-> $past(ctl_wr && key_ok))
    else $error("action started without key");
  AST_ACT_BEGIN: assert property (ACT_REQ_O.start |-> !STA_ACT_DONE_O)
    else $error("action done flag not cleared at start");
  AST_ACT_END: assert property (s_end |=> STA_ACT_DONE_O)
    else $error("action done flag not set");
  AST_CLS: assert property (s_cls |=> !STA_BOOT_DONE_O && !STA_ACT_DONE_O)
    else $error("status flags not cleared");
endmodule  // emc_regs_props
bind emc_regs emc_regs_props u_props (.CLK_SYS_I, .RST_B_I, .REG_ADDR_I, .REG_WDATA_I,
  .REG_WR_I, .REG_RD_I, .REG_RDATA_O, .REG_RVALID_O, .MEM_REQ_O, .ACT_REQ_O, .ACT_DONE_I,
  .BOOT_DONE_I, .STA_ACT_DONE_O, .STA_BOOT_DONE_O, .WARN_CLR_O, .ERR_CLR_O);
`default_nettype wire

// ==== test/emc_mem_model.sv ====
// memory and action engine stand-in on the far side
`timescale 1ns/10ps
`default_nettype none
module emc_mem_model (
  // clock, reset, pacing
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic [3:0]            lat_i,
  // requests
  input  wire emc_pkg::emc_mem_req_t req_i,
  input  wire emc_pkg::emc_act_req_t act_i,
  // answers
  output logic                       wr_ack_o,
  output logic                       rd_ack_o,
  output logic [31:0]                rdata_o,
  output logic                       act_done_o
);
  logic [31:0] mem_q [0:127];  // nonvolatile and shadow words
  logic [3:0]  wc_q, rc_q, ac_q;  // countdowns to each answer
  // answer each request lat_i cycles later
  always_ff @(posedge clk_i) begin
    wr_ack_o <= 1'b0;
    rd_ack_o <= 1'b0;
    act_done_o <= 1'b0;
    rdata_o <= ~rdata_o;  // word inverted every cycle between answers
    if (!rst_b_i) begin
      wc_q <= 4'h0;
      rc_q <= 4'h0;
      ac_q <= 4'h0;
      rdata_o <= 32'h5A5A_C3C3;
    end else begin
      if (req_i.wr_req) begin
        mem_q[req_i.wr_tgt[6:0]] <= req_i.wr_data;
        wc_q <= lat_i;
      end else if (wc_q != 4'h0) begin
        wc_q <= wc_q - 4'h1;
        wr_ack_o <= (wc_q == 4'h1);
      end
      if (req_i.rd_req) rc_q <= lat_i;
      else if (rc_q != 4'h0) begin
        rc_q <= rc_q - 4'h1;
        if (rc_q == 4'h1) begin
          rd_ack_o <= 1'b1;
          rdata_o <= mem_q[req_i.rd_tgt[6:0]];
        end
      end
      if (act_i.start) ac_q <= lat_i;
      else if (ac_q != 4'h0) begin
        ac_q <= ac_q - 4'h1;
        act_done_o <= (ac_q == 4'h1);
      end
    end
  end
endmodule  // emc_mem_model
`default_nettype wire

// ==== test/emc_regs_test.sv ====
// self-checking bench for the register bank
`timescale 1ns/10ps
`default_nettype none
module emc_regs_test;
  localparam int NV_WR = 20;  // shortened nonvolatile write time
  localparam int NV_RD = 10;  // shortened nonvolatile read time
  localparam logic [3:0] ACODE [9] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h7, 4'h7, 4'h9, 4'hA, 4'hB};
  localparam logic [7:0] AKEY [9] = '{8'hA5, 8'hA5, 8'h46, 8'hA5, 8'hA5, 8'h5A, 8'hB9, 8'hB9, 8'hB9};
  logic                  clk, rst_b, wr_s, rd_s, wack, rack, adone, unl, boot;
  logic                  rvalid, sdn, bdn, wclr, eclr;
  logic [7:0]            addr;
  logic [15:0]           wdata, rdata;
  logic [31:0]           mdata;
  logic [3:0]            lat;
  emc_pkg::emc_mem_req_t mreq;
  emc_pkg::emc_act_req_t areq;
  int                    err_total = 0, total_checks = 0, cyc = 0;
  emc_regs #(.NV_WR_CYC(NV_WR), .NV_RD_CYC(NV_RD)) dut (.CLK_SYS_I(clk), .RST_B_I(rst_b),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr_s), .REG_RD_I(rd_s),
    .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .MEM_REQ_O(mreq), .MEM_WR_ACK_I(wack),
    .MEM_RD_ACK_I(rack), .MEM_RDATA_I(mdata), .ACT_REQ_O(areq), .ACT_DONE_I(adone),
    .UNLOCKED_I(unl), .BOOT_DONE_I(boot), .STA_ACT_DONE_O(sdn), .STA_BOOT_DONE_O(bdn),
    .WARN_CLR_O(wclr), .ERR_CLR_O(eclr));
  emc_mem_model u_mem (.clk_i(clk), .rst_b_i(rst_b), .lat_i(lat), .req_i(mreq), .act_i(areq),
    .wr_ack_o(wack), .rd_ack_o(rack), .rdata_o(mdata), .act_done_o(adone));
  ////////////////
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      final_report;
    end
  end
  ////////////////
  // compare, bus cycles, verdict
  task chk(string n, logic [15:0] s, logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task put(logic [7:0] a, logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
  endtask
  task get(logic [7:0] a, output logic [15:0] d);
    @(negedge clk);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    chk("rvalid", 16'(rvalid), 16'h0001);
    d = rdata;
  endtask
  task poll(logic [7:0] a, output logic [15:0] v);
    for (int n = 0; n < 100; n++) begin
      get(a, v);
      if (v[0] === 1'b1) break;
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////
  // scenarios
  task t_regs;
    logic [15:0] v;
    put(8'h02, 16'hFFF5);
    get(8'h03, v);
    chk("target", v, 16'h00F5);
    put(8'h04, 16'hA55A);
    put(8'h07, 16'h3CC3);
    get(8'h04, v);
    chk("upper", v, 16'hA55A);
    get(8'h06, v);
    chk("lower", v, 16'h3CC3);
    put(8'h00, 16'hFFFF);
    get(8'h00, v);
    chk("null", v, 16'h0000);
    get(8'h12, v);
    chk("unmapped", v, 16'h0000);
    put(8'h08, 16'h7FFF);
    get(8'h08, v);
    chk("no_start", v, 16'h0000);
  endtask
  task t_clr;
    logic [15:0] v;
    @(negedge clk);
    boot = 1'b1;
    @(negedge clk);
    boot = 1'b0;
    chk("bdn", 16'(bdn), 16'h0001);
    put(8'h1E, 16'h0700);
    chk("bdn_clr", 16'(bdn), 16'h0000);
    chk("wclr", 16'(wclr), 16'h0001);
    chk("eclr", 16'(eclr), 16'h0001);
    get(8'h1E, v);
    chk("ctl", v, 16'h0000);
  endtask
  task xfer(logic [7:0] t, logic [31:0] d);
    logic [15:0] v;
    put(8'h02, {8'h00, t});
    put(8'h04, d[31:16]);
    put(8'h06, d[15:0]);
    put(8'h08, 16'h8000);
    get(8'h08, v);
    chk("wbusy", v, 16'h0100);
    poll(8'h08, v);
    chk("wdone", v, 16'h0001);
    put(8'h0A, {8'h00, t});
    put(8'h0C, 16'h8000);
    get(8'h0C, v);
    chk("rbusy", v, 16'h0100);
    poll(8'h0C, v);
    chk("rdone", v, 16'h0001);
    get(8'h0E, v);
    chk("rhi", v, d[31:16]);
    get(8'h10, v);
    chk("rlo", v, d[15:0]);
  endtask
  task t_act;
    logic [15:0] v;
    unl = 1'b1;
    for (int i = 0; i < 9; i++) begin
      put(8'h1E, {ACODE[i], 12'h000});
      put(8'h1E, {ACODE[i], 4'h0, AKEY[i]});
      chk("sdn_start", 16'(sdn), 16'h0000);
      for (int n = 0; n < 50 && sdn !== 1'b1; n++) @(negedge clk);
      chk("sdn_end", 16'(sdn), 16'h0001);
      get(8'h1E, v);
      chk("field", v, (ACODE[i] < 4'h3) ? {ACODE[i], 12'h000} : 16'h0000);
    end
    put(8'h1E, 16'h0400);
    chk("sdn_cls", 16'(sdn), 16'h0000);
    put(8'h1E, 16'h4000);
    put(8'h1E, 16'h40A5);
    unl = 1'b0;
    put(8'h1E, 16'h5000);
    put(8'h1E, 16'h50A5);
    repeat (8) @(negedge clk);
    chk("refused", 16'(sdn), 16'h0000);
    get(8'h1E, v);
    chk("held", v, 16'h5000);
  endtask
  ////////////////
  // main sequence
  initial begin
    {wr_s, rd_s, boot, unl} = 4'h0;
    addr = 8'h00;
    wdata = 16'h0000;
    lat = 4'h1;
    rst_b = 1'b0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    t_regs;
    t_clr;
    xfer(8'h05, 32'h1234_ABCD);
    lat = 4'h4;
    xfer(8'h45, 32'hFEDC_0246);
    t_act;
    final_report;
  end
endmodule  // emc_regs_test
`default_nettype wire
